// >>> hdl/tps_cfg.svh
// constants of the tamper monitor and supply-mode selector
// assumes a 10 MHz system clock and a 32.768 kHz oscillator time base
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH

// clock rates in hertz
`define TPS_CLK_HZ       10000000
`define TPS_OSC_HZ       32768

// tamper filter times in microseconds
`define TPS_FILT1_US     3900
`define TPS_FILT2_US     15625
`define TPS_FILT3_US     31250

// sampling periods in milliseconds (1/4 Hz, 1 Hz, 2 Hz)
`define TPS_SMP_Q_MS     4000
`define TPS_SMP_1_MS     1000
`define TPS_SMP_2_MS     500

// extra oscillator ticks a sample window stays open past the filter time
`define TPS_WIN_EXTRA    2

// filter select codes
`define TPS_FILT_NONE    2'h0
`define TPS_FILT_1       2'h1
`define TPS_FILT_2       2'h2
`define TPS_FILT_3       2'h3

// sample select codes
`define TPS_SMP_ALWAYS   2'h0
`define TPS_SMP_QUARTER  2'h1
`define TPS_SMP_ONE      2'h2
`define TPS_SMP_TWO      2'h3

// time stamp storage: six bytes, second first
`define TPS_STAMP_WIDTH  8
`define TPS_STAMP_DEPTH  6
`define TPS_STAMP_AW     3

// reset values
`define TPS_PWR_LOSS_RST 1'b1
`define TPS_FLAG_RST     1'b0

`endif

// >>> hdl/tps_pkg.sv
// types and helper functions of the tamper monitor
// assumes tps_cfg.svh is on the include path
`include "tps_cfg.svh"

package tps_pkg;

   // supply operating mode
   typedef enum logic {
      TPS_MAIN,
      TPS_BACKUP
   } tps_mode_t;

   typedef logic [10:0] tps_ticks_t;

   // least time in microseconds to oscillator ticks, rounded up
   function automatic tps_ticks_t tps_us_to_ticks(input int unsigned us);
      longint unsigned t;
      t = (longint'(us) * `TPS_OSC_HZ + 64'd999999) / 64'd1000000;
      return tps_ticks_t'(t);
   endfunction

   // filter select code to filter length in ticks
   function automatic tps_ticks_t tps_filter_ticks(input logic [1:0] sel);
      tps_ticks_t t;
      t = '0;
      unique case (sel)
         `TPS_FILT_NONE: t = '0;
         `TPS_FILT_1:    t = tps_us_to_ticks(`TPS_FILT1_US);
         `TPS_FILT_2:    t = tps_us_to_ticks(`TPS_FILT2_US);
         `TPS_FILT_3:    t = tps_us_to_ticks(`TPS_FILT3_US);
      endcase
      return t;
   endfunction

endpackage

// >>> hdl/tps_stamp_if.sv
// carrier between the monitor and its time stamp storage
// assumes one clock shared by both ends
`timescale 1ns/100ps

interface tps_stamp_if #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 6,
   parameter int AW    = 3
);
   logic                   we;
   logic [WIDTH*DEPTH-1:0] wdata;
   logic [AW-1:0]          raddr;
   logic [WIDTH-1:0]       rdata;

   modport ctl (output we, output wdata, output raddr, input rdata);
   modport mem (input we, input wdata, input raddr, output rdata);
endinterface

// >>> hdl/tps_stamp_mem.sv
// time stamp storage: all words captured at once, one read per cycle
// assumes the writer presents every word together on one strobe
`timescale 1ns/100ps

module tps_stamp_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 6,
   parameter int AW    = 3
) (
   input wire logic clock,
   input wire logic rst,
   tps_stamp_if.mem port
);
   logic [WIDTH-1:0] store [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // capture every word on the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) store[i] <= '0;
      end else if (port.we) begin
         for (int i = 0; i < DEPTH; i++) store[i] <= port.wdata[i*WIDTH +: WIDTH];
      end
   end

   // registered read, out-of-range reads as zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port.rdata <= '0;
      end else if (int'(port.raddr) < DEPTH) begin
         port.rdata <= store[port.raddr];
      end else begin
         port.rdata <= '0;
      end
   end
endmodule

// >>> hdl/tps_tamper_power.sv
// tamper input monitor and supply-mode selector, top level
// assumes rst is the power-on reset and comparator results come from analog
// blocks; all control bits are plain ports held by the register logic outside
`timescale 1ns/100ps
`include "tps_cfg.svh"

// Notes on behaviour
// - backup needs below-battery and below-trip
// - main again on either rising comparison
// - serial host interface off in backup
// - other pins stay live in backup
// - total power loss flag set at power-up
// - low power mode ignores trip comparison
// - no battery draw before first main power
// - valid high input sets tamper flag
// - detection drives output, captures time stamp
// - optional counter freeze on detection
// - software controls input pull-up
// - input must stay high filter time
// - continuous or 1/4, 1, 2 Hz sampling
// - sensing powered only inside sample window
// - detection works in main and backup
// - output low until flag cleared
// - disabled detection gates input off
// - bit chooses detection in backup mode
module tps_tamper_power
   import tps_pkg::*;
#(
   parameter int OSC_DIV     = `TPS_CLK_HZ / `TPS_OSC_HZ,
   parameter int SMP_Q_TICKS = `TPS_SMP_Q_MS * `TPS_OSC_HZ / 1000,
   parameter int SMP_1_TICKS = `TPS_SMP_1_MS * `TPS_OSC_HZ / 1000,
   parameter int SMP_2_TICKS = `TPS_SMP_2_MS * `TPS_OSC_HZ / 1000
) (
   input  wire logic        clock,
   input  wire logic        rst,
   // comparator results
   input  wire logic        vdd_below_bat,
   input  wire logic        vdd_above_bat,
   input  wire logic        vdd_below_trip,
   input  wire logic        vdd_above_trip_hys,
   // control bits
   input  wire logic        low_power_switch_select,
   input  wire logic        tamper_enable,
   input  wire logic        tamper_backup_enable_n,
   input  wire logic        tamper_out_enable,
   input  wire logic        halt_on_tamper,
   input  wire logic        input_pullup_control,
   input  wire logic [1:0]  tamper_filter_select,
   input  wire logic [1:0]  sample_select,
   input  wire logic        tamper_flag_clear,
   input  wire logic        power_loss_clear,
   // tamper pin and clock time
   input  wire logic        tamper_input_pin,
   input  wire logic [47:0] time_now,
   input  wire logic [2:0]  stamp_addr,
   // status and controls out
   output logic             tamper_flag,
   output logic             tamper_output,
   output logic             alarm_or_tamper_output_pin_o,
   output logic             alarm_or_tamper_output_pin_oe,
   output logic             total_power_loss_flag,
   output logic             backup_mode,
   output logic             serial_if_enable,
   output logic             battery_draw_enable,
   output logic             rtc_freeze,
   output logic             pullup_on,
   output logic             sense_enable,
   output logic [7:0]       stamp_data
);

   localparam int SMP_W = 18;

   ////////////////////////////////////////////////////////////////////////
   // oscillator time base as a one-cycle enable
   logic [15:0]      div_cnt;
   logic             osc_tick;

   assign osc_tick = (div_cnt == 16'(OSC_DIV - 1));

   // integer divide, so the tick runs slightly fast of the crystal rate;
   // filter and period lengths shrink by the same small ratio
   // free-running divider, the only slow rate in the block
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= osc_tick ? '0 : div_cnt + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // comparator synchronisers
   logic [3:0]       cmp_meta;
   logic [3:0]       cmp_sync;
   logic             below_bat_s;
   logic             above_bat_s;
   logic             below_trip_s;
   logic             above_trip_s;

   // two flops per comparator; a bit skewed by a cycle against its
   // neighbours only delays the mode decision, as all are levels
   // comparators settle asynchronously to our clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmp_meta <= 4'h0;
         cmp_sync <= 4'h0;
      end else begin
         cmp_meta <= {vdd_below_bat, vdd_above_bat, vdd_below_trip, vdd_above_trip_hys};
         cmp_sync <= cmp_meta;
      end
   end

   assign below_bat_s  = cmp_sync[3];
   assign above_bat_s  = cmp_sync[2];
   assign below_trip_s = cmp_sync[1];
   assign above_trip_s = cmp_sync[0];

   ////////////////////////////////////////////////////////////////////////
   // supply mode selection
   tps_mode_t        mode;
   tps_mode_t        next_mode;
   logic             armed;
   logic             want_backup;
   logic             want_main;
   logic             main_seen;

   // trip check dropped in low power mode; never leave for the battery unarmed
   assign want_backup = below_bat_s
                      & (low_power_switch_select | below_trip_s)
                      & armed;
   // either rising comparison returns; trip path unused in low power mode
   assign want_main   = above_bat_s | (~low_power_switch_select & above_trip_s);
   assign main_seen   = above_bat_s | above_trip_s;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         TPS_MAIN:   if (want_backup) next_mode = TPS_BACKUP;
         TPS_BACKUP: if (want_main) next_mode = TPS_MAIN;
      endcase
   end

   // hysteresis lives in the analog comparators; only their
   // combination is decided here
   // state only moves on oscillator ticks
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode <= TPS_MAIN;
      end else if (osc_tick) begin
         mode <= next_mode;
      end
   end

   // battery saver: armed once main supply has been seen after power-up
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         armed <= 1'b0;
      end else if (osc_tick && main_seen) begin
         armed <= 1'b1;
      end
   end

   assign backup_mode         = (mode == TPS_BACKUP);
   assign serial_if_enable    = ~backup_mode;
   assign battery_draw_enable = armed;

   // power-on reset here means both supplies were lost
   // limitation: nothing but reset sets the flag again
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         total_power_loss_flag <= `TPS_PWR_LOSS_RST;
      end else if (power_loss_clear) begin
         total_power_loss_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sampling windows
   logic [SMP_W-1:0] per_cnt;
   logic [SMP_W-1:0] per_len;
   logic             per_wrap;
   tps_ticks_t       filt_ticks;
   tps_ticks_t       win_cnt;
   logic             win_open;
   logic             continuous;

   assign filt_ticks = tps_filter_ticks(tamper_filter_select);
   assign continuous = (sample_select == `TPS_SMP_ALWAYS);
   // period length in ticks per sample rate
   assign per_len    = (sample_select == `TPS_SMP_QUARTER) ? SMP_W'(SMP_Q_TICKS) :
                       (sample_select == `TPS_SMP_ONE)     ? SMP_W'(SMP_1_TICKS) :
                                                             SMP_W'(SMP_2_TICKS);
   assign per_wrap   = (per_cnt >= per_len - SMP_W'(1));
   // window long enough for the whole filter to run inside it
   assign win_open   = (win_cnt < filt_ticks + tps_ticks_t'(`TPS_WIN_EXTRA));

   // a high that starts while the window is shut waits for the next
   // period start, trading detection latency for sensing current
   // period counter on ticks
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         per_cnt <= '0;
      end else if (continuous) begin
         per_cnt <= '0;
      end else if (osc_tick) begin
         per_cnt <= per_wrap ? '0 : per_cnt + SMP_W'(1);
      end
   end

   // window counter restarts at each period boundary
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         win_cnt <= '0;
      end else if (continuous || (osc_tick && per_wrap)) begin
         win_cnt <= '0;
      end else if (osc_tick && win_open) begin
         win_cnt <= win_cnt + tps_ticks_t'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input gating and filter
   logic             det_allowed;
   logic             gated_in;
   tps_ticks_t       filt_cnt;
   logic             valid_hi;
   logic             capture;

   // detection in backup only when the backup-enable bit allows it
   assign det_allowed  = tamper_enable
                       & (~backup_mode | ~tamper_backup_enable_n);
   assign sense_enable = det_allowed & (continuous | win_open);
   assign pullup_on    = sense_enable & input_pullup_control;
   assign gated_in     = tamper_input_pin & sense_enable;
   assign valid_hi     = gated_in & (filt_cnt >= filt_ticks);

   // any low restarts the count, so only a steady high qualifies
   // the count stops at the filter length, so a long high keeps
   // valid_hi up without the counter wrapping
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         filt_cnt <= '0;
      end else if (!gated_in) begin
         filt_cnt <= '0;
      end else if (osc_tick && filt_cnt < filt_ticks) begin
         filt_cnt <= filt_cnt + tps_ticks_t'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tamper flag and its effects
   logic             next_flag;

   // a clear while the pin is still high is overridden at once, so
   // software should clear only after the input has dropped
   // set wins over a clear in the same cycle
   assign next_flag = valid_hi | (tamper_flag & ~tamper_flag_clear);
   // stamp only the first detection so the recorded time stays put
   assign capture   = valid_hi & ~tamper_flag;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tamper_flag <= `TPS_FLAG_RST;
      end else begin
         tamper_flag <= next_flag;
      end
   end

   // output held by the flag itself, so it clears with it
   assign tamper_output                 = tamper_flag & tamper_out_enable & tamper_enable;
   // open drain; not gated by backup mode
   assign alarm_or_tamper_output_pin_o  = 1'b0;
   assign alarm_or_tamper_output_pin_oe = tamper_output;
   // freeze already in the detecting cycle
   assign rtc_freeze                    = halt_on_tamper & (tamper_flag | valid_hi);

   ////////////////////////////////////////////////////////////////////////
   // time stamp storage
   tps_stamp_if #(
      .WIDTH (`TPS_STAMP_WIDTH),
      .DEPTH (`TPS_STAMP_DEPTH),
      .AW    (`TPS_STAMP_AW)
   ) stamp_bus ();

   // stamp bytes come from time_now, second in the low byte
   assign stamp_bus.we    = capture;
   assign stamp_bus.wdata = time_now;
   assign stamp_bus.raddr = stamp_addr;
   assign stamp_data      = stamp_bus.rdata;

   tps_stamp_mem #(
      .WIDTH (`TPS_STAMP_WIDTH),
      .DEPTH (`TPS_STAMP_DEPTH),
      .AW    (`TPS_STAMP_AW)
   ) u_stamp (
      .clock (clock),
      .rst   (rst),
      .port  (stamp_bus.mem)
   );

endmodule

// >>> verification/tb.sv
// self-checking bench for the tamper monitor and supply-mode selector
// assumes short oscillator divide and sample periods so the run stays brief
`timescale 1ns/100ps

module tb;
   import tps_pkg::*;
   localparam int DIV    = 4;
   localparam int ft[4]  = '{0, 128, 512, 1024};
   localparam int per[4] = '{0, 64, 16, 8};
   logic        clock = 1'b0, rst = 1'b1, sw_open = 1'b0;
   logic        vdd_below_bat = 1'b0, vdd_above_bat = 1'b0, vdd_below_trip = 1'b0, vdd_above_trip_hys = 1'b0;
   logic        low_power_switch_select = 1'b0, tamper_enable = 1'b1, tamper_backup_enable_n = 1'b1;
   logic        tamper_out_enable = 1'b1, halt_on_tamper = 1'b0, input_pullup_control = 1'b1;
   logic        tamper_flag_clear = 1'b0, power_loss_clear = 1'b0, tamper_input_pin;
   logic [1:0]  tamper_filter_select = 2'h0, sample_select = 2'h0;
   logic [47:0] time_now = 48'h112233445566;
   logic [2:0]  stamp_addr = 3'h0;
   logic        tamper_flag, tamper_output, alarm_or_tamper_output_pin_o, alarm_or_tamper_output_pin_oe;
   logic        total_power_loss_flag, backup_mode, serial_if_enable, battery_draw_enable;
   logic        rtc_freeze, pullup_on, sense_enable;
   logic [7:0]  stamp_data;
   int          n_fail = 0, checks = 0;

   always #50 clock = ~clock;

   tps_tamper_power #(.OSC_DIV(DIV), .SMP_Q_TICKS(64), .SMP_1_TICKS(16), .SMP_2_TICKS(8)) dut (
      .clock, .rst, .vdd_below_bat, .vdd_above_bat, .vdd_below_trip, .vdd_above_trip_hys,
      .low_power_switch_select, .tamper_enable, .tamper_backup_enable_n, .tamper_out_enable,
      .halt_on_tamper, .input_pullup_control, .tamper_filter_select, .sample_select, .tamper_flag_clear,
      .power_loss_clear, .tamper_input_pin, .time_now, .stamp_addr, .tamper_flag, .tamper_output,
      .alarm_or_tamper_output_pin_o, .alarm_or_tamper_output_pin_oe, .total_power_loss_flag, .backup_mode,
      .serial_if_enable, .battery_draw_enable, .rtc_freeze, .pullup_on, .sense_enable, .stamp_data);

   tps_switch_model sw (.clock, .sw_open, .pullup_on, .pin(tamper_input_pin));

   ////////////////////////////////////////////////////////////////////////
   // helpers: drives land on rising edges, looks end on a falling edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // comparator set: below_bat, above_bat, below_trip, above_trip_hys
   task automatic supply(input logic [3:0] v);
      @(posedge clock);
      {vdd_below_bat, vdd_above_bat, vdd_below_trip, vdd_above_trip_hys} <= v;
      look(3 * DIV + 4);
   endtask

   // bounded wait for the flag; a timeout ends the run
   task automatic wait_flag(input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(negedge clock);
         if (tamper_flag === 1'b1) break;
      end
      if (n == lim) begin
         n_fail++;
         $display("Error at %0t: tamper flag timeout", $time);
         conclude();
      end
   endtask

   // close the switch and clear the flag once the input is low
   task automatic unflag();
      cyc(1);
      sw_open <= 1'b0;
      cyc(1);
      tamper_flag_clear <= 1'b1;
      cyc(1);
      tamper_flag_clear <= 1'b0;
      look(1);
      chk(tamper_flag, 1'b0);
      cyc(1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      look(1);
      chk(total_power_loss_flag, 1'b1);
      chk(battery_draw_enable, 1'b0);
      cyc(1);
      power_loss_clear <= 1'b1;
      cyc(1);
      power_loss_clear <= 1'b0;
      look(1);
      chk(total_power_loss_flag, 1'b0);
      supply(4'b1010);
      chk(backup_mode, 1'b0);
      supply(4'b0101);
      chk(battery_draw_enable, 1'b1);
      supply(4'b1000);
      chk(backup_mode, 1'b0);
      supply(4'b1010);
      chk(backup_mode, 1'b1);
      chk(serial_if_enable, 1'b0);
      cyc(1);
      sw_open <= 1'b1;
      look(20);
      chk(tamper_flag, 1'b0);
      cyc(1);
      tamper_backup_enable_n <= 1'b0;
      wait_flag(20, n);
      chk(tamper_output, 1'b1);
      chk(alarm_or_tamper_output_pin_oe, 1'b1);
      unflag();
      tamper_backup_enable_n <= 1'b1;
      supply(4'b1001);
      chk(backup_mode, 1'b0);
      cyc(1);
      low_power_switch_select <= 1'b1;
      look(3 * DIV + 4);
      chk(backup_mode, 1'b1);
      supply(4'b0101);
      chk(backup_mode, 1'b0);
      cyc(1);
      low_power_switch_select <= 1'b0;
      $display("test supply done");
      // every filter length, stamp checked on the first
      for (int f = 0; f < 4; f++) begin
         cyc(1);
         tamper_filter_select <= 2'(f);
         sw_open <= 1'b1;
         wait_flag(1100 * DIV, n);
         chk(8'(n >= ft[f] * DIV - DIV - 2 && n <= ft[f] * DIV + DIV + 3), 8'h1);
         if (f == 0) begin
            chk(alarm_or_tamper_output_pin_oe, 1'b1);
            for (int i = 0; i < 6; i++) begin
               cyc(1);
               stamp_addr <= 3'(i);
               look(1);
               chk(stamp_data, time_now[8 * i +: 8]);
            end
         end
         unflag();
      end
      // a drop before the filter expires restarts the count
      tamper_filter_select <= 2'h1;
      sw_open <= 1'b1;
      look(100 * DIV);
      chk(tamper_flag, 1'b0);
      cyc(1);
      sw_open <= 1'b0;
      cyc(2);
      sw_open <= 1'b1;
      wait_flag(200 * DIV, n);
      chk(8'(n >= 127 * DIV), 8'h1);
      unflag();
      tamper_filter_select <= 2'h0;
      $display("test filter done");
      // disabled input with floating pin, then freeze on detection
      tamper_enable <= 1'b0;
      input_pullup_control <= 1'b0;
      sw_open <= 1'b1;
      look(20);
      chk(tamper_flag, 1'b0);
      chk(pullup_on, 1'b0);
      cyc(1);
      input_pullup_control <= 1'b1;
      tamper_enable <= 1'b1;
      halt_on_tamper <= 1'b1;
      tamper_out_enable <= 1'b0;
      wait_flag(20, n);
      chk(rtc_freeze, 1'b1);
      chk(tamper_output, 1'b0);
      chk(alarm_or_tamper_output_pin_oe, 1'b0);
      unflag();
      look(0);
      chk(rtc_freeze, 1'b0);
      cyc(1);
      halt_on_tamper <= 1'b0;
      tamper_out_enable <= 1'b1;
      $display("test enable done");
      // sampled sensing at every rate
      for (int s = 1; s < 4; s++) begin
         cyc(1);
         sample_select <= 2'(s);
         look(4 * DIV);
         chk(sense_enable, 1'b0);
         chk(pullup_on, 1'b0);
         cyc(1);
         sw_open <= 1'b1;
         wait_flag(per[s] * DIV + 4 * DIV, n);
         chk(8'(n >= (per[s] - 6) * DIV), 8'h1);
         unflag();
         sample_select <= 2'h0;
         cyc(2 * DIV);
      end
      $display("test sampling done");
      conclude();
   end
endmodule

bind tps_tamper_power tps_tamper_power_sva #(.OSC_DIV(OSC_DIV)) u_sva (
   .clock, .rst, .vdd_below_bat, .vdd_above_bat, .vdd_below_trip, .vdd_above_trip_hys,
   .low_power_switch_select, .tamper_enable, .tamper_out_enable, .halt_on_tamper, .input_pullup_control,
   .tamper_filter_select, .tamper_flag_clear, .tamper_input_pin, .tamper_flag, .tamper_output,
   .alarm_or_tamper_output_pin_o, .alarm_or_tamper_output_pin_oe, .backup_mode, .serial_if_enable,
   .battery_draw_enable, .rtc_freeze, .pullup_on, .sense_enable);

// >>> verification/tps_switch_model.sv
// external tamper switch: closed shorts the pin to ground
// assumes the pin rises only through the internal pull-up when open
`timescale 1ns/100ps

module tps_switch_model (
   input  wire logic clock,
   input  wire logic sw_open,
   input  wire logic pullup_on,
   output logic      pin
);
   logic drift = 1'b0;

   // floating pin wanders so an unpowered pull-up is never read as a level
   always @(posedge clock) drift <= ~drift;
   assign pin = !sw_open ? 1'b0 : (pullup_on ? 1'b1 : drift);
endmodule

// >>> verification/tps_tamper_power_sva.sv
// checker for the tamper monitor and supply-mode selector
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps

module tps_tamper_power_sva #(
   parameter int OSC_DIV = 305
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       vdd_below_bat,
   input wire logic       vdd_above_bat,
   input wire logic       vdd_below_trip,
   input wire logic       vdd_above_trip_hys,
   input wire logic       low_power_switch_select,
   input wire logic       tamper_enable,
   input wire logic       tamper_out_enable,
   input wire logic       halt_on_tamper,
   input wire logic       input_pullup_control,
   input wire logic [1:0] tamper_filter_select,
   input wire logic       tamper_flag_clear,
   input wire logic       tamper_input_pin,
   input wire logic       tamper_flag,
   input wire logic       tamper_output,
   input wire logic       alarm_or_tamper_output_pin_o,
   input wire logic       alarm_or_tamper_output_pin_oe,
   input wire logic       backup_mode,
   input wire logic       serial_if_enable,
   input wire logic       battery_draw_enable,
   input wire logic       rtc_freeze,
   input wire logic       pullup_on,
   input wire logic       sense_enable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // cycles the raw pin has stayed high; saturates so long holds stay high
   logic [15:0] hi_cnt;
   always_ff @(posedge clock or posedge rst)
      if (rst) hi_cnt <= '0;
      else if (!tamper_input_pin) hi_cnt <= '0;
      else if (hi_cnt != 16'hffff) hi_cnt <= hi_cnt + 16'h1;

   ////////////////////////////////////////////////////////////////////////
   // supply mode
   a_serial_off_backup: assert property (serial_if_enable == !backup_mode)
      else $error("serial interface enable does not follow supply mode");
   a_no_early_draw: assert property (!battery_draw_enable |-> !backup_mode)
      else $error("backup entered before main supply seen");
   // comparators reach the mode logic through two flops, hence depth 3
   a_backup_cause: assert property ($rose(backup_mode) |->
      $past(vdd_below_bat, 3) && ($past(vdd_below_trip, 3) || $past(low_power_switch_select)))
      else $error("backup mode entered without its conditions");
   a_main_cause: assert property ($fell(backup_mode) |->
      $past(vdd_above_bat, 3) || ($past(vdd_above_trip_hys, 3) && !$past(low_power_switch_select)))
      else $error("main mode resumed without its conditions");

   ////////////////////////////////////////////////////////////////////////
   // tamper detection
   a_out_follows_flag: assert property (tamper_output == (tamper_flag && tamper_out_enable && tamper_enable))
      else $error("tamper output does not follow flag");
   a_pin_pull_low: assert property (alarm_or_tamper_output_pin_oe == tamper_output
      && !alarm_or_tamper_output_pin_o)
      else $error("output pin drive wrong");
   a_pullup_gate: assert property (pullup_on == (sense_enable && input_pullup_control))
      else $error("pull-up state wrong");
   a_flag_sticky: assert property (tamper_flag && !tamper_flag_clear |=> tamper_flag)
      else $error("tamper flag dropped without clear");
   a_disabled_gate: assert property (!tamper_enable && !tamper_flag |=> !tamper_flag)
      else $error("tamper flag set while detection disabled");
   a_filter_hold: assert property ($rose(tamper_flag) && tamper_filter_select == 2'h1
      |-> hi_cnt >= 16'(127 * OSC_DIV))
      else $error("detection before filter time");
   a_freeze_on_flag: assert property (halt_on_tamper && tamper_flag |-> rtc_freeze)
      else $error("counters not frozen on tamper");

   c_backup: cover property ($rose(backup_mode));
   c_long_filter: cover property ($rose(tamper_flag) && tamper_filter_select == 2'h3);
   c_sample_off: cover property ($fell(sense_enable));
endmodule
